// ---- dv/mmb_prog_store.sv ----
// Program store model: 2K words of 14 bits that answer the fetch port of the block.
// Assumes the block already folds the fetch address onto the implemented 2K words.
`timescale 1ns/1ps
module mmb_prog_store
    import mmb_pkg::*;
(
    // Fetch request from the block
    input  wire mmb_pkg::mmb_fetch_s fetch_i,
    // Program word back to the block
    output logic [13:0]              insn_o
);
    always_comb begin
        insn_o = {3'h5, fetch_i.mem_addr};
    end
endmodule : mmb_prog_store

// ---- dv/test_mmb_memory_map.sv ----
// Bench for the memory map block: Wishbone tasks drive the program counter and data map.
// Assumes the program store model on the fetch port and a 10 MHz core clock.
`timescale 1ns/1ps
module test_mmb_memory_map;
    import mmb_pkg::*;
    logic        clk_i = 1'h0;
    logic        rst_i = 1'h1;
    logic        cyc = 1'h0;
    logic        stb = 1'h0;
    logic        we = 1'h0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'hF;
    logic [3:0]  use_sel = 4'hF;
    logic [31:0] wdat = 32'h0;
    logic [31:0] q;
    logic [31:0] dat_o;
    logic        ack;
    logic        absent;
    logic [13:0] insn_i;
    logic [13:0] insn_o;
    logic [7:0]  drdata;
    mmb_fetch_s  fetch;
    int          n_mismatch = 0;
    int          n_checks = 0;
    int          cyc_cnt = 0;

    always #50 clk_i = ~clk_i;

    mmb_memory_map mmb_memory_map_i (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .fetch_o(fetch), .insn_i(insn_i), .insn_o(insn_o), .drdata_o(drdata),
        .bank_absent_o(absent)
    );
    mmb_prog_store mmb_prog_store_i (.fetch_i(fetch), .insn_o(insn_i));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk_i);
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= use_sel;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'h1 && n < 20);
        q = dat_o;
        if (n >= 20) n_mismatch++;
        cyc <= 1'h0;
        stb <= 1'h0;
        we <= 1'h0;
        @(posedge clk_i);
    endtask : wb

    // Data access through the block: offset, write data, then start
    task automatic dacc(input logic ind, input logic w, input logic [6:0] ofs, input logic [7:0] d);
        wb(1'h1, WB_DADDR, {25'h0, ofs});
        wb(1'h1, WB_DDATA, {24'h0, d});
        wb(1'h1, WB_CTRL, (32'h1 << CTRL_GO) | ({31'h0, w} << CTRL_WRITE) | ({31'h0, ind} << CTRL_INDIR));
    endtask : dacc

    task automatic drd(input logic ind, input logic [6:0] ofs, input logic [7:0] exp);
        dacc(ind, 1'h0, ofs, 8'h00);
        wb(1'h0, WB_DDATA, 32'h0);
        chk(q, {24'h0, exp});
        chk({24'h0, drdata}, {24'h0, exp});
    endtask : drd

    task automatic stat(input logic [7:0] v);
        wb(1'h1, WB_STAT, {24'h0, v});
    endtask : stat

    // Counter, fetch port and returned word all follow the same address
    task automatic pcchk(input logic [12:0] exp);
        wb(1'h0, WB_PC, 32'h0);
        chk(q, {19'h0, exp});
        chk({19'h0, fetch.pc}, {19'h0, exp});
        chk({21'h0, fetch.mem_addr}, {21'h0, exp[10:0]});
        chk({18'h0, insn_o}, {18'h0, 3'h5, exp[10:0]});
    endtask : pcchk

    task automatic tend(input string s);
        $display("test %s done", s);
    endtask : tend

    task automatic test_done;
        $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : test_done

    always @(posedge clk_i) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 4000) begin
            n_mismatch++;
            test_done();
        end
    end

    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'h0;
        wb(1'h0, WB_STAT, 32'h0);
        chk(q, 32'h18);
        pcchk(13'h0000);
        wb(1'h0, 8'h14, 32'h0);
        chk(q, 32'h0);
        tend("reset");
        wb(1'h1, WB_CTRL, 32'h1 << CTRL_INT);
        pcchk(13'h0004);
        wb(1'h1, WB_CTRL, 32'h1 << CTRL_STEP);
        pcchk(13'h0005);
        dacc(1'h0, 1'h1, OFS_PROGRAM_COUNTER_HIGH_LATCH, 8'h08);
        dacc(1'h0, 1'h1, OFS_PCL, 8'h05);
        pcchk(13'h0805);
        stat(8'h38);
        dacc(1'h0, 1'h1, OFS_PROGRAM_COUNTER_HIGH_LATCH, 8'hFF);
        stat(8'h18);
        drd(1'h0, OFS_PROGRAM_COUNTER_HIGH_LATCH, 8'h1F);
        dacc(1'h0, 1'h1, OFS_PCL, 8'hFF);
        pcchk(13'h1FFF);
        drd(1'h0, OFS_PCL, 8'hFF);
        wb(1'h1, WB_CTRL, 32'h1 << CTRL_STEP);
        pcchk(13'h0000);
        tend("program");
        dacc(1'h0, 1'h1, 7'h20, 8'h5A);
        dacc(1'h0, 1'h1, 7'h7F, 8'hC3);
        stat(8'h38);
        dacc(1'h0, 1'h1, 7'h20, 8'hA5);
        dacc(1'h0, 1'h1, 7'h40, 8'h99);
        dacc(1'h0, 1'h1, OFS_PTR, 8'h20);
        drd(1'h0, 7'h20, 8'hA5);
        drd(1'h0, 7'h40, 8'h00);
        drd(1'h0, 7'h7F, 8'h00);
        drd(1'h0, OFS_STATUS, 8'h38);
        stat(8'h18);
        drd(1'h0, 7'h20, 8'h5A);
        drd(1'h0, 7'h7F, 8'hC3);
        drd(1'h0, OFS_PTR, 8'h20);
        dacc(1'h0, 1'h1, 7'h60, 8'h66);
        stat(8'h38);
        drd(1'h0, 7'h20, 8'hA5);
        stat(8'h18);
        drd(1'h0, 7'h60, 8'h66);
        tend("banks");
        drd(1'h0, OFS_INDIRECT, 8'h5A);
        drd(1'h1, 7'h55, 8'h5A);
        dacc(1'h0, 1'h1, OFS_PTR, 8'hA1);
        dacc(1'h0, 1'h1, OFS_INDIRECT, 8'h3C);
        stat(8'h38);
        drd(1'h0, 7'h21, 8'h3C);
        tend("indirect");
        stat(8'h58);
        chk({31'h0, absent}, 32'h1);
        dacc(1'h0, 1'h1, 7'h20, 8'h77);
        drd(1'h0, 7'h20, 8'h00);
        stat(8'h78);
        chk({31'h0, absent}, 32'h1);
        drd(1'h0, 7'h20, 8'h00);
        stat(8'h18);
        chk({31'h0, absent}, 32'h0);
        drd(1'h0, 7'h20, 8'h5A);
        stat(8'h98);
        drd(1'h1, 7'h00, 8'h00);
        stat(8'h18);
        use_sel = 4'hE;
        stat(8'h38);
        use_sel = 4'hF;
        wb(1'h0, WB_STAT, 32'h0);
        chk(q, 32'h18);
        tend("absent");
        test_done();
    end
endmodule : test_mmb_memory_map

// ---- rtl/mmb_gpr_ram.sv ----
// Byte-wide general purpose RAM held in flip-flops, one write port, one async read port.
// Assumes the caller decodes the address range; writes need a valid index.
`timescale 1ns/1ps
module mmb_gpr_ram #(
    parameter int DEPTH = 128
) (
    // Clock
    input  wire logic                     clk_i,
    // Write port
    input  wire logic                     we_i,
    input  wire logic [$clog2(DEPTH)-1:0] waddr_i,
    input  wire logic [7:0]               wdata_i,
    // Read port
    input  wire logic [$clog2(DEPTH)-1:0] raddr_i,
    output logic      [7:0]               rdata_o
);
    import mmb_pkg::*;

    logic [7:0] mem_reg [DEPTH];

    if (DEPTH < 2) begin : g_depth_check
        $error("DEPTH too small");
    end

    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem_reg[waddr_i] <= wdata_i;
        end
    end

    assign rdata_o = mem_reg[raddr_i];
endmodule : mmb_gpr_ram

// ---- rtl/mmb_memory_map.sv ----
// Memory map and bank decode: program counter, vectors, bank select, mirrored core registers,
// direct and indirect data access. Registers reachable over classic Wishbone; single clock.
//
// Overview of operation
// - Fetch and data access use separate ports, usable in one cycle.
// - Program counter is thirteen bits, spanning eight K words.
// - Two K fourteen-bit program words are implemented.
// - Fetch addresses above the last word wrap onto implemented memory.
// - Reset starts fetching at address zero.
// - A taken interrupt jumps to address four.
// - Two status bits pick the bank; banks two and three are absent.
// - Each bank spans a seven-bit offset, 128 bytes.
// - Special function registers occupy the lowest offsets of banks zero and one.
// - General purpose RAM sits above the special function area.
// - Every implemented bank holds special function registers.
// - Core registers are mirrored so banks zero and one both reach them.
// - Data is addressed directly or through the pointer register.
`timescale 1ns/1ps
module mmb_memory_map #(
    parameter int GPR_DEPTH = mmb_pkg::GPR_DEPTH
) (
    // Clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    // Wishbone slave
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [7:0]           wb_adr_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic [31:0]          wb_dat_i,
    output logic      [31:0]          wb_dat_o,
    output logic                      wb_ack_o,
    // Program memory port
    output mmb_pkg::mmb_fetch_s       fetch_o,
    input  wire logic [13:0]          insn_i,
    output logic      [13:0]          insn_o,
    // Data access status
    output logic      [7:0]           drdata_o,
    output logic                      bank_absent_o
);
    import mmb_pkg::*;

    // Bank 0 and bank 1 RAM fill the store exactly
    if (GPR_DEPTH != mmb_pkg::GPR_DEPTH) begin : g_depth_check
        $error("GPR_DEPTH must match the data map");
    end

    // Core registers
    logic [12:0] pc_reg;
    logic [7:0]  status_reg;
    logic [7:0]  ptr_reg;
    logic [7:0]  program_counter_high_latch_reg;
    logic [7:0]  daddr_reg;
    logic [7:0]  ddata_reg;
    logic [13:0] insn_reg;
    logic        ack_reg;
    logic [31:0] rdat_reg;

    // Bank and offset of a data access
    function automatic logic [8:0] eff_addr(input logic indirect, input logic [6:0] ofs,
                                            input logic [7:0] status, input logic [7:0] ptr);
        logic [8:0] a;
        a = '0;
        if (indirect) begin
            a = {status[STAT_IRP_BIT], ptr};
        end else begin
            a = {status[STAT_BSH_BIT], status[STAT_BSL_BIT], ofs};
        end
        return a;
    endfunction : eff_addr

    function automatic logic gpr_hit(input logic [8:0] a);
        logic ok;
        ok = 1'b0;
        if (a[8:7] == 2'b00) begin
            ok = (a[6:0] >= OFS_GPR_LO);
        end else if (a[8:7] == 2'b01) begin
            ok = (a[6:0] >= OFS_GPR_LO) && (a[6:0] <= OFS_B1_GPR_HI);
        end
        return ok;
    endfunction : gpr_hit

    // Wishbone decode
    logic wb_req;
    logic wb_wr;
    logic go;
    assign wb_req   = wb_cyc_i && wb_stb_i && !ack_reg;
    assign wb_wr    = wb_req && wb_we_i && wb_sel_i[0];
    assign go       = wb_wr && (wb_adr_i == WB_CTRL) && wb_dat_i[CTRL_GO];
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdat_reg;

    // Data access request: go, write and indirect from the control word, offset and data from the staging registers
    mmb_dreq_s req;
    always_comb begin
        req.valid    = go;
        req.write    = wb_dat_i[CTRL_WRITE];
        req.indirect = wb_dat_i[CTRL_INDIR];
        req.offset   = daddr_reg[6:0];
        req.wdata    = ddata_reg;
    end

    logic [8:0] ea;
    logic       via_ptr;
    assign via_ptr = req.indirect || (req.offset == OFS_INDIRECT);
    assign ea      = eff_addr(via_ptr, req.offset, status_reg, ptr_reg);

    logic bank_ok;
    assign bank_ok       = !ea[8];
    assign bank_absent_o = status_reg[STAT_BSH_BIT];

    logic is_pcl;
    logic is_status;
    logic is_ptr;
    logic is_program_counter_high_latch;
    logic is_gpr;
    assign is_pcl    = bank_ok && (ea[6:0] == OFS_PCL);
    assign is_status = bank_ok && (ea[6:0] == OFS_STATUS);
    assign is_ptr    = bank_ok && (ea[6:0] == OFS_PTR);
    assign is_program_counter_high_latch = bank_ok && (ea[6:0] == OFS_PROGRAM_COUNTER_HIGH_LATCH);
    assign is_gpr    = gpr_hit(ea);

    // seven-bit offset, bank 1 RAM in the spare low entries
    logic [6:0] ram_idx;
    logic [7:0] ram_rd;
    assign ram_idx = ea[7] ? (ea[6:0] - OFS_GPR_LO) : ea[6:0];

    mmb_gpr_ram #(
        .DEPTH (GPR_DEPTH)
    ) u_ram (
        .clk_i   (clk_i),
        .we_i    (req.valid && req.write && is_gpr),
        .waddr_i (ram_idx),
        .wdata_i (req.wdata),
        .raddr_i (ram_idx),
        .rdata_o (ram_rd)
    );

    // special area read mux; zero elsewhere
    logic [7:0] dread;
    always_comb begin
        dread = 8'h00;
        if (is_gpr) begin
            dread = ram_rd;
        end else if (is_pcl) begin
            dread = pc_reg[7:0];
        end else if (is_status) begin
            dread = status_reg;
        end else if (is_ptr) begin
            dread = ptr_reg;
        end else if (is_program_counter_high_latch) begin
            dread = program_counter_high_latch_reg & PROGRAM_COUNTER_HIGH_LATCH_MASK;
        end
    end

    // direct or pointer access, core register writes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_reg <= STATUS_RST;
            ptr_reg    <= 8'h00;
            program_counter_high_latch_reg <= 8'h00;
        end else if (wb_wr && (wb_adr_i == WB_STAT)) begin
            status_reg <= wb_dat_i[7:0];
        end else if (req.valid && req.write) begin
            if (is_status) begin
                status_reg <= req.wdata;
            end
            if (is_ptr) begin
                ptr_reg <= req.wdata;
            end
            if (is_program_counter_high_latch) begin
                program_counter_high_latch_reg <= req.wdata & PROGRAM_COUNTER_HIGH_LATCH_MASK;
            end
        end
    end

    // Captured read data of the last read access
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            drdata_o <= 8'h00;
        end else if (req.valid && !req.write) begin
            drdata_o <= dread;
        end
    end

    // Staging registers for the data access
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            daddr_reg <= 8'h00;
            ddata_reg <= 8'h00;
        end else if (wb_wr && (wb_adr_i == WB_DADDR)) begin
            daddr_reg <= wb_dat_i[7:0];
        end else if (wb_wr && (wb_adr_i == WB_DDATA)) begin
            ddata_reg <= wb_dat_i[7:0];
        end
    end

    // program counter; reset vector; interrupt vector
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pc_reg <= RESET_VECTOR;
        end else if (go && req.write && is_pcl) begin
            pc_reg <= {program_counter_high_latch_reg[4:0], req.wdata};
        end else if (wb_wr && (wb_adr_i == WB_CTRL) && wb_dat_i[CTRL_INT]) begin
            pc_reg <= INT_VECTOR;
        end else if (wb_wr && (wb_adr_i == WB_CTRL) && wb_dat_i[CTRL_STEP]) begin
            pc_reg <= pc_reg + 13'h0001;
        end
    end

    // separate fetch port; low bits address 2K words
    assign fetch_o.pc       = pc_reg;
    assign fetch_o.mem_addr = pc_reg[PROG_IMPL_W-1:0];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            insn_reg <= 14'h0000;
        end else begin
            insn_reg <= insn_i;
        end
    end
    assign insn_o = insn_reg;

    // Wishbone answer, one wait state, unmapped reads zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg  <= 1'b0;
            rdat_reg <= 32'h0000_0000;
        end else begin
            ack_reg  <= wb_req;
            rdat_reg <= 32'h0000_0000;
            if (wb_req) begin
                unique case (wb_adr_i)
                    WB_STAT:  rdat_reg <= {24'h000000, status_reg};
                    WB_DADDR: rdat_reg <= {24'h000000, daddr_reg};
                    WB_DDATA: rdat_reg <= {24'h000000, drdata_o};
                    WB_PC:    rdat_reg <= {19'h00000, pc_reg};
                    default:  rdat_reg <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Assertions
    property p_reset_vec;
        @(posedge clk_i) rst_i |=> (pc_reg == RESET_VECTOR);
    endproperty
    a_reset_vec: assert property (p_reset_vec) else $error("pc not zero after reset");

    property p_int_vec;
        @(posedge clk_i) disable iff (rst_i)
        (wb_wr && wb_adr_i == WB_CTRL && wb_dat_i[CTRL_INT] && !(go && req.write && is_pcl))
        |=> (pc_reg == INT_VECTOR);
    endproperty
    a_int_vec: assert property (p_int_vec) else $error("interrupt vector not four");

    property p_wrap;
        @(posedge clk_i) disable iff (rst_i) fetch_o.mem_addr == pc_reg[10:0];
    endproperty
    a_wrap: assert property (p_wrap) else $error("fetch address does not wrap");

    property p_absent_zero;
        @(posedge clk_i) disable iff (rst_i)
        (req.valid && !req.write && ea[8]) |=> (drdata_o == 8'h00);
    endproperty
    a_absent_zero: assert property (p_absent_zero) else $error("absent bank read not zero");

    property p_mirror;
        @(posedge clk_i) disable iff (rst_i)
        (req.valid && !req.write && is_status) |=> (drdata_o == $past(status_reg));
    endproperty
    a_mirror: assert property (p_mirror) else $error("status mirror mismatch");

    property p_ptr_wr;
        @(posedge clk_i) disable iff (rst_i)
        (req.valid && req.write && is_ptr && !(wb_adr_i == WB_STAT)) |=> (ptr_reg == $past(req.wdata));
    endproperty
    a_ptr_wr: assert property (p_ptr_wr) else $error("pointer write lost");

    sequence s_req;
        wb_req;
    endsequence
    sequence s_ack;
        ack_reg ##1 !ack_reg;
    endsequence
    property p_ack;
        @(posedge clk_i) disable iff (rst_i) s_req |=> s_ack;
    endproperty
    a_ack: assert property (p_ack) else $error("ack timing wrong");

    property p_bank_absent;
        @(posedge clk_i) disable iff (rst_i)
        (req.valid && req.write && !via_ptr && bank_absent_o)
        |=> ($stable(status_reg) && $stable(ptr_reg) && $stable(program_counter_high_latch_reg));
    endproperty
    a_bank_absent: assert property (p_bank_absent) else $error("absent bank write landed");
endmodule : mmb_memory_map

// ---- rtl/mmb_pkg.sv ----
// Package for the memory map and bank decode block: map offsets, field positions, widths.
// Assumes a single core clock and a synchronous active-high reset.
package mmb_pkg;
    // Program space
    localparam int          PC_W          = 13;
    localparam int          INSN_W        = 14;
    localparam int          PROG_IMPL_W   = 11;
    localparam logic [12:0] RESET_VECTOR  = 13'h0000;
    localparam logic [12:0] INT_VECTOR    = 13'h0004;
    // Data space
    localparam int          OFS_W         = 7;
    localparam int          DADDR_W       = 9;
    localparam logic [6:0]  OFS_INDIRECT  = 7'h00;
    localparam logic [6:0]  OFS_PCL       = 7'h02;
    localparam logic [6:0]  OFS_STATUS    = 7'h03;
    localparam logic [6:0]  OFS_PTR       = 7'h04;
    localparam logic [6:0]  OFS_PROGRAM_COUNTER_HIGH_LATCH    = 7'h0A;
    localparam logic [6:0]  OFS_GPR_LO    = 7'h20;
    localparam logic [6:0]  OFS_B1_GPR_HI = 7'h3F;
    localparam int          GPR_DEPTH     = 128;
    localparam int          STAT_BSL_BIT  = 5;
    localparam int          STAT_BSH_BIT  = 6;
    localparam int          STAT_IRP_BIT  = 7;
    localparam logic [7:0]  STATUS_RST    = 8'h18;
    localparam logic [7:0]  PROGRAM_COUNTER_HIGH_LATCH_MASK   = 8'h1F;
    // Wishbone register window (word addresses = index * 4)
    localparam logic [7:0]  WB_CTRL       = 8'h00;
    localparam logic [7:0]  WB_STAT       = 8'h04;
    localparam logic [7:0]  WB_DADDR      = 8'h08;
    localparam logic [7:0]  WB_DDATA      = 8'h0C;
    localparam logic [7:0]  WB_PC         = 8'h10;
    localparam int          CTRL_STEP     = 0;
    localparam int          CTRL_INT      = 1;
    localparam int          CTRL_INDIR    = 2;
    localparam int          CTRL_WRITE    = 3;
    localparam int          CTRL_GO       = 4;

    typedef struct packed {
        logic       valid;
        logic       write;
        logic       indirect;
        logic [6:0] offset;
        logic [7:0] wdata;
    } mmb_dreq_s;

    typedef struct packed {
        logic [12:0] pc;
        logic [10:0] mem_addr;
    } mmb_fetch_s;
endpackage : mmb_pkg
